// [dbglk_top.sv]
// debug lock latch top: key latch, nonvolatile cells, reset sampling
// Function
// - latch holds 32 bits; lock when at least 28 match the pattern
// - locked part disables test, programming and debug ports; protection raise and latch readback stay available
// - locked part refuses any erase or change of latch contents
// - latch output is only evaluated at reset to decide access
// - lock needs key loaded, committed to cells, then a reset
// - key write accepted only while no flash protection is set
// - access stays granted after key write until next reset
// - latch contents readable through the serial debug port
// - protection may be raised anytime, cleared only by full erase or by reset
// - per block erase/program/verify only when block setting allows
// - full device erase then whole device program and verify
`timescale 1ns/10ps
module dbglk_top
  import dbglk_pkg::*;
#(
  parameter int BLK_N = DBGLK_BLK_N
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire dbglk_host_req_s host_req,
  input wire logic blk_op_req,
  input wire logic [$clog2(BLK_N)-1:0] blk_sel,
  input wire logic [BLK_N-1:0] blk_allow,
  input wire logic [DBGLK_KEY_W-1:0] nv_cell_init,
  output dbglk_status_s status,
  output logic blk_op_grant,
  output logic full_erase_grant,
  output logic nv_cell_wr,
  output logic [DBGLK_KEY_W-1:0] nv_cell_wdata
);
  dbglk_state_e state_reg;
  logic [DBGLK_KEY_W-1:0] vol_key_reg;
  logic [DBGLK_KEY_W-1:0] nv_key_reg;
  logic [1:0] prot_reg;
  logic locked_reg;
  logic ok_reg;
  logic rej_reg;
  logic commit_reg;
  logic vote;
  logic loaded_reg;
  logic wr_ok;
  logic wr_req;
  logic commit_ok;

  dbglk_vote #(
    .KEY_W(DBGLK_KEY_W),
    .MATCH_MIN(DBGLK_MATCH_MIN)
  ) u_vote (
    .bits(nv_key_reg),
    .pattern(DBGLK_LOCK_PATTERN),
    .match(vote)
  );

  // sequencer: reset, one sample cycle, run
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= DBGLK_ST_RESET;
    end else begin
      unique case (state_reg)
        DBGLK_ST_RESET: state_reg <= DBGLK_ST_SAMPLE;
        DBGLK_ST_SAMPLE: state_reg <= DBGLK_ST_RUN;
        DBGLK_ST_RUN: state_reg <= DBGLK_ST_RUN;
        default: state_reg <= DBGLK_ST_RESET;
      endcase
    end
  end

  // nonvolatile cells are read into the shadow after reset release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nv_key_reg <= DBGLK_KEY_RST;
      loaded_reg <= 1'b0;
    end else if (!loaded_reg) begin
      nv_key_reg <= nv_cell_init;
      loaded_reg <= 1'b1;
    end
  end

  // sample vote only once at reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      locked_reg <= 1'b1;
    end else if (state_reg == DBGLK_ST_SAMPLE) begin
      locked_reg <= vote;
    end
  end

  wire run = (state_reg == DBGLK_ST_RUN);
  wire port_en = run && !locked_reg;

  assign wr_req = host_req.key_wr && run;
  // write allowed only unlocked and unprotected
  assign wr_ok = wr_req && !locked_reg && (prot_reg == DBGLK_PROT_RST);

  // key loaded to volatile storage first
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vol_key_reg <= DBGLK_KEY_RST;
      ok_reg <= 1'b0;
      rej_reg <= 1'b0;
    end else begin
      ok_reg <= wr_ok;
      rej_reg <= wr_req && !wr_ok;
      if (wr_ok) begin
        vol_key_reg <= host_req.key_data;
      end
    end
  end

  // commit refused while locked or protected
  assign commit_ok = port_en && host_req.commit &&
                     (prot_reg == DBGLK_PROT_RST);

  // commit volatile key to the cells
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      commit_reg <= 1'b0;
      nv_cell_wdata <= DBGLK_KEY_RST;
    end else begin
      commit_reg <= commit_ok;
      if (commit_ok) begin
        nv_cell_wdata <= vol_key_reg;
      end
    end
  end
  assign nv_cell_wr = commit_reg;

  // raise anytime, clear only by full erase or by reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prot_reg <= DBGLK_PROT_RST;
    end else if (port_en && host_req.erase_all) begin
      prot_reg <= DBGLK_PROT_RST;
    end else if (run && host_req.prot_raise &&
                 host_req.prot_level > prot_reg) begin
      prot_reg <= host_req.prot_level;
    end
  end

  // ports open unless locked at reset
  always_comb begin
    status = '0;
    status.locked = locked_reg;
    status.port_enable = port_en;
    status.key_wr_ok = ok_reg;
    status.key_wr_rej = rej_reg;
    status.latch_rd = nv_key_reg;
    status.prot_level = prot_reg;
  end

  // block operation gated by block setting
  assign blk_op_grant = port_en && blk_op_req && blk_allow[blk_sel];
  assign full_erase_grant = port_en && host_req.erase_all;

  // checks on lock decision, gating and key path
  a_lock_stable: assert property (
    @(posedge clock) disable iff (!rst_n)
    $past(state_reg) == DBGLK_ST_RUN |-> $stable(locked_reg))
    else $error("lock changed during run");
  a_ports_off: assert property (
    @(posedge clock) disable iff (!rst_n)
    locked_reg |-> !status.port_enable && !blk_op_grant)
    else $error("port open while locked");
  a_wr_reject: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr_req && (locked_reg || prot_reg != DBGLK_PROT_RST) |=> rej_reg)
    else $error("bad key write not rejected");
  a_key_kept: assert property (
    @(posedge clock) disable iff (!rst_n)
    locked_reg |=> $stable(vol_key_reg) && !nv_cell_wr)
    else $error("latch altered while locked");
  a_prot_clear: assert property (
    @(posedge clock) disable iff (!rst_n)
    $fell(|prot_reg) |-> $past(full_erase_grant))
    else $error("protection cleared without erase");
  a_sample_vote: assert property (
    @(posedge clock) disable iff (!rst_n)
    state_reg == DBGLK_ST_SAMPLE |=> locked_reg == $past(vote))
    else $error("lock not taken from vote");
  a_blk_gate: assert property (
    @(posedge clock) disable iff (!rst_n)
    blk_op_grant |-> blk_allow[blk_sel])
    else $error("block op granted against setting");
  a_open_after_wr: assert property (
    @(posedge clock) disable iff (!rst_n)
    ok_reg |-> status.port_enable)
    else $error("access lost after key write");
  a_closed_boot: assert property (
    @(posedge clock) disable iff (!rst_n)
    state_reg != DBGLK_ST_RUN |-> locked_reg && !status.port_enable)
    else $error("access open before lock decision");
  a_cells_load: assert property (
    @(posedge clock) disable iff (!rst_n)
    state_reg == DBGLK_ST_SAMPLE |-> nv_key_reg == $past(nv_cell_init))
    else $error("cells not read at reset");
  a_wr_accept: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr_req && !locked_reg && prot_reg == DBGLK_PROT_RST |=>
    status.key_wr_ok && vol_key_reg == $past(host_req.key_data))
    else $error("good key write not taken");
  a_commit_key: assert property (
    @(posedge clock) disable iff (!rst_n)
    run && !locked_reg && host_req.commit &&
    prot_reg == DBGLK_PROT_RST |=>
    nv_cell_wr && nv_cell_wdata == $past(vol_key_reg))
    else $error("commit did not program the key");
  a_commit_refused: assert property (
    @(posedge clock) disable iff (!rst_n)
    locked_reg || prot_reg != DBGLK_PROT_RST |=> !nv_cell_wr)
    else $error("cells written while locked or protected");
  a_prot_raise: assert property (
    @(posedge clock) disable iff (!rst_n)
    run && host_req.prot_raise && !host_req.erase_all &&
    host_req.prot_level > prot_reg |=>
    prot_reg == $past(host_req.prot_level))
    else $error("protection raise lost");
  a_prot_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    $changed(prot_reg) |->
    $past(full_erase_grant) || prot_reg > $past(prot_reg))
    else $error("protection lowered without erase");
  a_erase_clear: assert property (
    @(posedge clock) disable iff (!rst_n)
    full_erase_grant |=> prot_reg == DBGLK_PROT_RST)
    else $error("full erase left protection set");

  // main scenarios
  c_locked: cover property (@(posedge clock) run && locked_reg);
  c_commit: cover property (@(posedge clock) nv_cell_wr);
  c_reject: cover property (@(posedge clock) rej_reg);
  c_accept: cover property (@(posedge clock) status.key_wr_ok);
  c_erase: cover property (@(posedge clock)
    full_erase_grant && prot_reg != DBGLK_PROT_RST);
endmodule // dbglk_top

// [dbglk_pkg.sv]
// package for the debug lock latch block
package dbglk_pkg;
  localparam int DBGLK_KEY_W = 32;
  localparam int DBGLK_MATCH_MIN = 28;
  localparam int DBGLK_CNT_W = 6;
  localparam int DBGLK_BLK_N = 8;
  // lock pattern value is arbitrary, not the part's real key
  localparam logic [31:0] DBGLK_LOCK_PATTERN = 32'hA5C3_3C5A;
  localparam logic [31:0] DBGLK_KEY_RST = 32'h0000_0000;
  localparam logic [1:0] DBGLK_PROT_RST = 2'h0;
  localparam int DBGLK_SETTLE_CYC = 2;

  typedef enum logic [1:0] {
    DBGLK_ST_RESET = 2'b00,
    DBGLK_ST_SAMPLE = 2'b01,
    DBGLK_ST_RUN = 2'b11
  } dbglk_state_e;

  typedef struct packed {
    logic key_wr;
    logic [31:0] key_data;
    logic commit;
    logic erase_all;
    logic prot_raise;
    logic [1:0] prot_level;
  } dbglk_host_req_s;

  typedef struct packed {
    logic locked;
    logic port_enable;
    logic key_wr_ok;
    logic key_wr_rej;
    logic [31:0] latch_rd;
    logic [1:0] prot_level;
  } dbglk_status_s;
endpackage

// [dbglk_vote.sv]
// threshold vote of stored key bits against the lock pattern
`timescale 1ns/10ps
module dbglk_vote
  import dbglk_pkg::*;
#(
  parameter int KEY_W = DBGLK_KEY_W,
  parameter int MATCH_MIN = DBGLK_MATCH_MIN
) (
  input wire logic [KEY_W-1:0] bits,
  input wire logic [KEY_W-1:0] pattern,
  output logic match
);
  logic [KEY_W-1:0] eq;
  logic [DBGLK_CNT_W-1:0] cnt;

  assign eq = ~(bits ^ pattern);

  always_comb begin
    cnt = '0;
    for (int i = 0; i < KEY_W; i++) begin
      cnt = cnt + DBGLK_CNT_W'(eq[i]);
    end
  end

  assign match = (cnt >= DBGLK_CNT_W'(MATCH_MIN));
endmodule // dbglk_vote

// [dbglk_host.sv]
// host model driving the debug lock request struct
`timescale 1ns/10ps
module dbglk_host
  import dbglk_pkg::*;
(
  input wire logic [2:0] cmd,
  input wire logic [31:0] arg,
  output dbglk_host_req_s host_req
);
  always_comb begin
    host_req = '0;
    host_req.key_wr = (cmd == 3'h1);
    host_req.key_data = arg;
    host_req.commit = (cmd == 3'h2);
    host_req.prot_raise = (cmd == 3'h3);
    host_req.prot_level = arg[1:0];
    host_req.erase_all = (cmd == 3'h4);
  end
endmodule // dbglk_host

// [debug_lock_latch_tb.sv]
// self-checking bench for the debug lock latch
`timescale 1ns/10ps
module debug_lock_latch_tb;
  import dbglk_pkg::*;
  logic clock, rst_n, blk_op_req, blk_op_grant, full_erase_grant, nv_cell_wr;
  logic [2:0] cmd, blk_sel;
  logic [31:0] arg, nv_cell_init, nv_cell_wdata, seed, m, c;
  logic [7:0] blk_allow;
  dbglk_host_req_s host_req;
  dbglk_status_s status;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  dbglk_host i_host (.cmd(cmd), .arg(arg), .host_req(host_req));
  dbglk_top i_dut (.clock(clock), .rst_n(rst_n), .host_req(host_req),
    .blk_op_req(blk_op_req), .blk_sel(blk_sel), .blk_allow(blk_allow),
    .nv_cell_init(nv_cell_init), .status(status),
    .blk_op_grant(blk_op_grant), .full_erase_grant(full_erase_grant),
    .nv_cell_wr(nv_cell_wr), .nv_cell_wdata(nv_cell_wdata));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic exp_lock(input logic [31:0] v);
    return $countones(v ~^ DBGLK_LOCK_PATTERN) >= DBGLK_MATCH_MIN;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic step(input logic [2:0] k, input logic [31:0] a);
    cmd = k;
    arg = a;
    @(negedge clock);
  endtask
  task automatic boot(input logic [31:0] cells);
    rst_n = 1'b0;
    cmd = 3'h0;
    nv_cell_init = cells;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
  endtask
  task automatic complete_run();
    $display("mismatches %0d checks %0d", fail_count, check_count);
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      $display("BAD %0t timeout", $time);
      complete_run();
    end
  end
  initial begin
    {arg, blk_op_req, blk_sel, blk_allow} = '0;
    seed = 32'h228DEC06;
    for (int n = 0; n < 8; n++) begin
      seed = lfsr(seed);
      m = (32'h1 << n) - 32'h1;
      m = (m << seed[4:0]) | (m >> (6'd32 - seed[4:0]));
      c = DBGLK_LOCK_PATTERN ^ m;
      boot(c);
      chk(status.locked, exp_lock(c));
      chk(status.port_enable, !exp_lock(c));
      chk(status.latch_rd, c);
      step(3'h1, seed);
      chk({status.key_wr_ok, status.key_wr_rej}, exp_lock(c) ? 1 : 2);
    end
    seed = lfsr(seed);
    boot(seed);
    blk_op_req = 1'b1;
    for (int i = 0; i < 8; i++) begin
      blk_allow = seed[7:0] ^ 8'(i);
      blk_sel = 3'(i);
      #1 chk(blk_op_grant, blk_allow[i]);
      @(negedge clock);
    end
    step(3'h1, DBGLK_LOCK_PATTERN);
    chk(status.key_wr_ok, 1);
    step(3'h2, 0);
    chk(nv_cell_wr, 1);
    chk(nv_cell_wdata, DBGLK_LOCK_PATTERN);
    chk({status.locked, status.port_enable}, 1);
    step(3'h3, 2);
    chk(status.prot_level, 2);
    step(3'h1, DBGLK_LOCK_PATTERN);
    chk(status.key_wr_rej, 1);
    cmd = 3'h4;
    #1 chk(full_erase_grant, 1);
    @(negedge clock);
    chk(status.prot_level, 0);
    boot(DBGLK_LOCK_PATTERN);
    chk({status.locked, blk_op_grant}, 2);
    step(3'h1, DBGLK_LOCK_PATTERN);
    chk(status.key_wr_rej, 1);
    cmd = 3'h4;
    #1 chk(full_erase_grant, 0);
    complete_run();
  end
endmodule // debug_lock_latch_tb
